// ===== rtl/sxcp_cfg.svh
// Constants of the sysex-controlled crosspoint: bytes, parameters, counts.
// Operation
// - Frame: start, maker, model, ID, type, pairs, end.
// - Act only on own ID or broadcast.
// - Request type 10 triggers full value dump.
// - Dump is one frame, type 30h, after request.
// - Set-value pairs applied in order until end.
// - Total reset: ID 00, presets cleared, live selected.
// - Each output takes one input; fan-out allowed.
// - Any pairing allowed, including own number.
// - Ports 1-6 coaxial, 7-8 optical, both sides.
// - Routed bitstream passes raw, never reclocked.
// - Remote lock ignores frames, thru continues.
// - Every input byte retransmitted unchanged.
// - Preset number 0-9 stored, 0A live view.
// - Routing byte: 0 none, 1-8 input number.
`ifndef SXCP_CFG_SVH
`define SXCP_CFG_SVH
`define SXCP_SOX 8'hf0
`define SXCP_EOX 8'hf7
`define SXCP_RT_MIN 8'hf8
`define SXCP_BCAST 8'h7f
`define SXCP_ID_MAX 8'h7e
`define SXCP_MT_REQ 8'h10
`define SXCP_MT_SET 8'h20
`define SXCP_MT_RSP 8'h30
`define SXCP_P_PRESET 8'h05
`define SXCP_P_STORE 8'h06
`define SXCP_P_RECALL 8'h07
`define SXCP_P_KEYLK 8'h08
`define SXCP_P_MIDILK 8'h09
`define SXCP_P_DEVID 8'h0a
`define SXCP_P_ROUTE 8'h10
`define SXCP_P_ROUTE_END 8'h57
`define SXCP_LIVE 4'ha
`define SXCP_NPRESET 10
`define SXCP_ROUTE_MAX 4'h8
`define SXCP_HDR_LAST 2'h3
`define SXCP_DUMP_HDR 8'h07
`define SXCP_DUMP_FIX 7'h04
`define SXCP_DUMP_LAST 8'h9f
`endif

// ===== rtl/sxcp_pkg.sv
// Types shared by the crosspoint controller.
package sxcp_pkg;
  // Parser position inside an incoming frame.
  typedef enum logic [2:0] {S_IDLE, S_HDR, S_DEV, S_TYPE, S_PNUM, S_PVAL,
    S_REQ, S_SKIP} sxcp_state_t;
  // One routing selection, 0 for no input, 1 to 8 for an input.
  typedef logic [3:0] sxcp_sel_t;
  // A byte travelling on the serial MIDI side with its strobe.
  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
  } sxcp_byte_t;
endpackage

// ===== rtl/sxcp_top.sv
// Sysex command interpreter, byte FIFO and raw 8x8 crosspoint.
`include "sxcp_cfg.svh"

// Byte FIFO between the MIDI receiver and the frame parser.
module sxcp_fifo
  import sxcp_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage words.
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // Write and read pointers.
  logic [AW:0] cnt_r, cnt_nxt; // Fill level.
  logic push, pop;
  // Full and empty both come from the fill level, so they never lie.
  always_comb
  begin
    in_ready = (cnt_r != (AW+1)'(D));
    out_valid = (cnt_r != '0);
    out_data = mem[rp_r];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  // Pointer registers; the array itself has no reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule

// Top: parses frames, keeps presets, sends dumps and thru bytes.
module sxcp_top
  import sxcp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter logic [23:0] MAKER_ID = 24'h01_02_03, // Arbitrary value.
  parameter logic [7:0] MODEL_ID = 8'h11 // Arbitrary value.
)
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  input wire logic TX_READY,
  input wire logic REMOTE_LOCK,
  input wire logic KEY_LOCK,
  output logic [6:0] DEVICE_ID,
  output logic [3:0] PRESET_SEL,
  output logic [31:0] ROUTE,
  input wire logic [7:0] STREAM_IN,
  output logic [7:0] STREAM_OUT
);
  wire sxcp_byte_t fo; // FIFO head byte, each field driven by one port.
  logic pop, tx_free;
  sxcp_state_t state_r, state_nxt;
  logic [1:0] idx_r, idx_nxt; // Header byte position.
  logic [7:0] pnum_r, pnum_nxt; // Parameter number awaiting its value.
  logic [6:0] id_r, id_nxt;
  logic [3:0] sel_r, sel_nxt;
  sxcp_sel_t live_r [8], live_nxt [8]; // Current routing.
  sxcp_sel_t pre_r [`SXCP_NPRESET][8], pre_nxt [`SXCP_NPRESET][8];
  logic dump_r, dump_nxt; // A value-response frame is being sent.
  logic [7:0] step_r, step_nxt; // Byte index inside that frame.
  logic tv_r, tv_nxt;
  logic [7:0] tb_r, tb_nxt;

  // Expected header byte after the start byte.
  function automatic logic [7:0] hdr_byte(input logic [1:0] i);
    if (i == 2'h0)
      return MAKER_ID[23:16];
    else if (i == 2'h1)
      return MAKER_ID[15:8];
    else if (i == 2'h2)
      return MAKER_ID[7:0];
    else
      return MODEL_ID;
  endfunction

  sxcp_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo
  (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .in_valid(RX_VALID),
    .in_data(RX_BYTE),
    .in_ready(RX_READY),
    .out_valid(fo.valid),
    .out_data(fo.data),
    .out_ready(pop)
  );

  // While a dump is going out the FIFO is not drained, so a busy link
  // back-pressures the sender instead of dropping thru bytes.
  assign tx_free = !tv_r || TX_READY;
  assign pop = fo.valid && !dump_r && tx_free;

  // Raw combinational path: reclocking would tie it to our clock.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_xp
      sxcp_sel_t m1;
      assign m1 = live_r[g] - 4'h1;
      assign STREAM_OUT[g] = (live_r[g] == '0) ? 1'b0 : STREAM_IN[m1[2:0]];
      assign ROUTE[4*g +: 4] = live_r[g];
    end
  endgenerate

  // Next state of parser, settings, presets and transmitter.
  always_comb
  begin
    logic [7:0] b, k;
    logic [6:0] pr, r;
    b = fo.data;
    k = step_r - `SXCP_DUMP_HDR;
    pr = k[7:1];
    r = pr - `SXCP_DUMP_FIX;
    state_nxt = state_r;
    idx_nxt = idx_r;
    pnum_nxt = pnum_r;
    id_nxt = id_r;
    sel_nxt = sel_r;
    live_nxt = live_r;
    pre_nxt = pre_r;
    dump_nxt = dump_r;
    step_nxt = step_r;
    tv_nxt = tv_r && !TX_READY;
    tb_nxt = tb_r;
    if (pop)
    begin
      // Thru copy of every received byte.
      tv_nxt = 1'b1;
      tb_nxt = b;
    end
    else if (dump_r && tx_free)
    begin
      // Value-response frame, one byte per free slot.
      tv_nxt = 1'b1;
      step_nxt = step_r + 8'h1;
      if (step_r == 8'h0)
        tb_nxt = `SXCP_SOX;
      else if (step_r < 8'h5)
        tb_nxt = hdr_byte(2'(step_r - 8'h1));
      else if (step_r == 8'h5)
        tb_nxt = {1'b0, id_r};
      else if (step_r == 8'h6)
        tb_nxt = `SXCP_MT_RSP;
      else if (step_r == `SXCP_DUMP_LAST)
      begin
        tb_nxt = `SXCP_EOX;
        dump_nxt = 1'b0;
      end
      else if (!k[0])
      begin
        // Parameter number of the pair.
        if (pr == 7'h0)
          tb_nxt = `SXCP_P_PRESET;
        else if (pr == 7'h1)
          tb_nxt = `SXCP_P_KEYLK;
        else if (pr == 7'h2)
          tb_nxt = `SXCP_P_MIDILK;
        else if (pr == 7'h3)
          tb_nxt = `SXCP_P_DEVID;
        else
          tb_nxt = `SXCP_P_ROUTE + {1'b0, r};
      end
      else
      begin
        // Value of the pair.
        if (pr == 7'h0)
          tb_nxt = {4'h0, sel_r};
        else if (pr == 7'h1)
          tb_nxt = {7'h0, KEY_LOCK};
        else if (pr == 7'h2)
          tb_nxt = {7'h0, REMOTE_LOCK};
        else if (pr == 7'h3)
          tb_nxt = {1'b0, id_r};
        else
          tb_nxt = {4'h0, pre_r[r[6:3] + 4'h1][r[2:0]]};
      end
    end
    if (pop)
    begin
      if (REMOTE_LOCK)
        state_nxt = S_IDLE;
      else if (b >= `SXCP_RT_MIN)
        state_nxt = state_r; // Real-time bytes may sit inside a frame.
      else if (b == `SXCP_SOX)
      begin
        state_nxt = S_HDR;
        idx_nxt = 2'h0;
      end
      else if (b[7] && b != `SXCP_EOX)
        state_nxt = S_IDLE;
      else
        case (state_r)
          S_HDR:
            if (b != hdr_byte(idx_r))
              state_nxt = S_SKIP;
            else if (idx_r == `SXCP_HDR_LAST)
              state_nxt = S_DEV;
            else
              idx_nxt = idx_r + 2'h1;
          S_DEV:
            if (b == `SXCP_BCAST || b == {1'b0, id_r})
              state_nxt = S_TYPE;
            else
              state_nxt = S_SKIP;
          S_TYPE:
            if (b == `SXCP_MT_REQ)
              state_nxt = S_REQ;
            else if (b == `SXCP_MT_SET)
              state_nxt = S_PNUM;
            else
              state_nxt = S_SKIP;
          S_REQ:
          begin
            state_nxt = (b == `SXCP_EOX) ? S_IDLE : S_SKIP;
            if (b == `SXCP_EOX)
            begin
              dump_nxt = 1'b1;
              step_nxt = 8'h0;
            end
          end
          S_PNUM:
          begin
            state_nxt = (b == `SXCP_EOX) ? S_IDLE : S_PVAL;
            pnum_nxt = b;
          end
          S_PVAL:
          begin
            // Apply this pair at once, in arrival order.
            state_nxt = (b == `SXCP_EOX) ? S_IDLE : S_PNUM;
            if (b == `SXCP_EOX)
              state_nxt = S_IDLE;
            else if (pnum_r == `SXCP_P_PRESET && b <= {4'h0, `SXCP_LIVE})
              sel_nxt = b[3:0];
            else if (pnum_r == `SXCP_P_STORE && b == 8'h1
              && sel_r < `SXCP_LIVE)
              pre_nxt[sel_r] = live_r;
            else if (pnum_r == `SXCP_P_RECALL && b == 8'h1
              && sel_r < `SXCP_LIVE)
              live_nxt = pre_r[sel_r];
            else if (pnum_r == `SXCP_P_DEVID && b <= `SXCP_ID_MAX)
              id_nxt = b[6:0];
            else if (pnum_r >= `SXCP_P_ROUTE && pnum_r <= `SXCP_P_ROUTE_END
              && b <= {4'h0, `SXCP_ROUTE_MAX})
            begin
              r = 7'(pnum_r - `SXCP_P_ROUTE);
              pre_nxt[r[6:3] + 4'h1][r[2:0]] = b[3:0];
            end
          end
          default:
            if (b == `SXCP_EOX)
              state_nxt = S_IDLE;
        endcase
    end
  end

  // Registers; reset gives the factory state.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      state_r <= S_IDLE;
      idx_r <= 2'h0;
      pnum_r <= 8'h0;
      id_r <= 7'h0;
      sel_r <= `SXCP_LIVE;
      live_r <= '{default: 4'h0};
      pre_r <= '{default: '{default: 4'h0}};
      dump_r <= 1'b0;
      step_r <= 8'h0;
      tv_r <= 1'b0;
      tb_r <= 8'h0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      pnum_r <= pnum_nxt;
      id_r <= id_nxt;
      sel_r <= sel_nxt;
      live_r <= live_nxt;
      pre_r <= pre_nxt;
      dump_r <= dump_nxt;
      step_r <= step_nxt;
      tv_r <= tv_nxt;
      tb_r <= tb_nxt;
    end
  end

  assign TX_VALID = tv_r;
  assign TX_BYTE = tb_r;
  assign DEVICE_ID = id_r;
  assign PRESET_SEL = sel_r;

  // Checks that tie outputs and state to their causes.
  sequence seq_req_end;
    pop && !REMOTE_LOCK && state_r == S_REQ && fo.data == `SXCP_EOX;
  endsequence
  sequence seq_dump_open;
    dump_r && step_r == 8'h0 && tx_free;
  endsequence
  chk_thru_copy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    pop |=> TX_VALID && TX_BYTE == $past(fo.data))
    else $error("received byte not retransmitted");
  chk_lock_ignore: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    pop && REMOTE_LOCK |=> state_r == S_IDLE && TX_VALID)
    else $error("locked parser left idle");
  chk_req_dump: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    seq_req_end |=> dump_r && step_r == 8'h0)
    else $error("request did not start a dump");
  chk_dump_start: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    seq_dump_open |=> TX_VALID && TX_BYTE == `SXCP_SOX)
    else $error("dump does not open with start byte");
  chk_dump_type: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    dump_r && step_r == 8'h6 && tx_free |=> TX_BYTE == `SXCP_MT_RSP)
    else $error("dump message type wrong");
  chk_dump_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    dump_r && !tx_free |=> dump_r && $stable(step_r) && $stable(TX_BYTE))
    else $error("stalled dump byte not held");
  chk_foreign_id: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    pop && !REMOTE_LOCK && state_r == S_DEV && !fo.data[7]
    && fo.data != `SXCP_BCAST && fo.data != {1'b0, id_r}
    |=> state_r == S_SKIP)
    else $error("foreign device ID accepted");
  chk_reset_state: assert property (@(posedge REF_CLK)
    SYS_RST |=> DEVICE_ID == 7'h0 && PRESET_SEL == `SXCP_LIVE && ROUTE == '0)
    else $error("reset state wrong");
  chk_sel_range: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    PRESET_SEL <= `SXCP_LIVE && DEVICE_ID != 7'h7f)
    else $error("preset or ID out of range");
  chk_route_mux: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ROUTE[3:0] == 4'h8 |-> STREAM_OUT[0] == STREAM_IN[7])
    else $error("wrap-around route not passed raw");
endmodule

// ===== tb/sxcp_sink.sv
// Far-side MIDI receiver model that takes transmitted bytes with stalls.
module sxcp_sink
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$]; // Every byte taken, in arrival order.
  // A byte counts only where valid and ready meet at an edge.
  // Random stalls keep the transmit slot busy at awkward moments.
  always @(posedge clk)
  begin
    if (!rst && tx_valid && tx_ready)
      q.push_back(tx_byte);
    // Ready stays low through reset so nothing is taken from a reset link.
    tx_ready <= !rst && !hold && ($urandom % 4 != 0);
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the sysex crosspoint controller.
`include "sxcp_cfg.svh"
module tb_top;
  import sxcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] MK = 24'h01_02_03; // Arbitrary maker code.
  localparam logic [7:0] MD = 8'h11; // Arbitrary model code.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic lock = 1'b0;
  logic key = 1'b0;
  logic hold = 1'b0;
  logic [7:0] s_in = 8'h00;
  logic rx_ready, tx_valid, tx_ready;
  logic [7:0] tx_byte, s_out;
  logic [6:0] dev_id;
  logic [3:0] psel;
  logic [31:0] route;
  logic [7:0] fq[$]; // Frame being built.
  logic [7:0] eq[$]; // Bytes expected back on the thru path.
  sxcp_sel_t sel[8]; // Routing written to preset 1.
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  always #25 clk = ~clk;
  sxcp_top #(.MAKER_ID(MK), .MODEL_ID(MD)) sxcp_top_inst (.REF_CLK(clk),
    .SYS_RST(rst), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
    .TX_READY(tx_ready), .REMOTE_LOCK(lock), .KEY_LOCK(key),
    .DEVICE_ID(dev_id), .PRESET_SEL(psel), .ROUTE(route),
    .STREAM_IN(s_in), .STREAM_OUT(s_out));
  sxcp_sink sxcp_sink_inst (.clk(clk), .rst(rst), .hold(hold),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [7:0] b);
    fq.push_back(b);
  endtask
  // Start byte, maker, model, address and message type of one frame.
  task automatic head(input logic [7:0] id, mt);
    put(`SXCP_SOX);
    for (int i = 2; i >= 0; i--)
      put(MK[8*i +: 8]);
    put(MD);
    put(id);
    put(mt);
  endtask
  // Offers the built bytes one by one, holding each until it is taken.
  task automatic go();
    eq.delete();
    sxcp_sink_inst.q.delete();
    foreach (fq[k])
    begin
      rx_valid <= 1'b1;
      rx_byte <= fq[k];
      eq.push_back(fq[k]);
      #1;
      while (rx_ready !== 1'b1)
      begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    fq.delete();
  endtask
  // Waits, bounded, for every echoed byte plus extra, then compares.
  task automatic drain(input int extra);
    for (int i = 0; i < 4000; i++)
    begin
      if (sxcp_sink_inst.q.size() >= eq.size() + extra)
        break;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk("tx count", eq.size() + extra, sxcp_sink_inst.q.size());
    foreach (eq[k])
      chk("thru byte", eq[k], sxcp_sink_inst.q[k]);
  endtask
  function automatic logic [31:0] pack();
    logic [31:0] r;
    for (int m = 0; m < 8; m++)
      r[4*m +: 4] = sel[m];
    return r;
  endfunction
  // Each output follows its selected input bit, or rests at 0.
  function automatic logic [7:0] mux(input logic [31:0] r, logic [7:0] s);
    logic [7:0] o;
    for (int m = 0; m < 8; m++)
      o[m] = (r[4*m +: 4] == 4'h0) ? 1'b0 : s[3'(r[4*m +: 4] - 4'h1)];
    return o;
  endfunction
  // A hang ends the run as a failure.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(32'h64cf8657));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    key <= 1'($urandom);
    @(posedge clk);
    #1;
    chk("id", 32'h0, {25'h0, dev_id});
    chk("preset", 32'ha, {28'h0, psel});
    chk("route", 32'h0, route);
    @(posedge clk);
    head(8'h00, `SXCP_MT_SET);
    put(8'h0a);
    put(8'h15);
    put(`SXCP_EOX);
    go();
    drain(0);
    chk("id set", 32'h15, {25'h0, dev_id});
    for (int m = 0; m < 8; m++)
      sel[m] = 4'($urandom % 9);
    sel[0] = 4'h8;
    sel[1] = 4'h2;
    head(8'h15, `SXCP_MT_SET);
    put(8'h05);
    put(8'h01);
    put(8'h10);
    put(8'h03);
    for (int m = 0; m < 8; m++)
    begin
      put(8'(8'h10 + m));
      put({4'h0, sel[m]});
    end
    put(8'h07);
    put(8'h01);
    put(`SXCP_EOX);
    go();
    drain(0);
    chk("preset", 32'h1, {28'h0, psel});
    chk("route", pack(), route);
    repeat (8)
    begin
      @(posedge clk);
      s_in <= 8'($urandom);
      #1;
      chk("stream", {24'h0, mux(pack(), s_in)}, {24'h0, s_out});
    end
    head(8'h16, `SXCP_MT_SET);
    put(8'h0a);
    put(8'h22);
    put(`SXCP_EOX);
    head(8'h7f, `SXCP_MT_SET);
    // Spoil the first maker byte of this frame so its header fails.
    fq[11] = fq[11] ^ 8'h01;
    put(8'h0a);
    put(8'h23);
    put(`SXCP_EOX);
    head(8'h7f, `SXCP_MT_SET);
    put(8'h0a);
    head(8'h7f, `SXCP_MT_SET);
    put(8'h05);
    put(8'h02);
    put(`SXCP_EOX);
    go();
    drain(0);
    chk("id kept", 32'h15, {25'h0, dev_id});
    chk("preset", 32'h2, {28'h0, psel});
    lock <= 1'b1;
    head(8'h7f, `SXCP_MT_SET);
    put(8'h0a);
    put(8'h33);
    put(`SXCP_EOX);
    go();
    drain(0);
    chk("id locked", 32'h15, {25'h0, dev_id});
    lock <= 1'b0;
    head(8'h15, `SXCP_MT_REQ);
    put(`SXCP_EOX);
    go();
    drain(160);
    n = eq.size();
    chk("dump start", 32'hf0, {24'h0, sxcp_sink_inst.q[n]});
    chk("dump id", 32'h15, {24'h0, sxcp_sink_inst.q[n+5]});
    chk("dump type", 32'h30, {24'h0, sxcp_sink_inst.q[n+6]});
    chk("dump sel", 32'h2, {24'h0, sxcp_sink_inst.q[n+8]});
    chk("dump key", {31'h0, key}, {24'h0, sxcp_sink_inst.q[n+10]});
    chk("dump lock", 32'h0, {24'h0, sxcp_sink_inst.q[n+12]});
    chk("dump pnum", 32'h10, {24'h0, sxcp_sink_inst.q[n+15]});
    chk("dump route", {28'h0, sel[0]}, {24'h0, sxcp_sink_inst.q[n+16]});
    chk("dump end", 32'hf7, {24'h0, sxcp_sink_inst.q[n+159]});
    // Stalled far side: the buffer must fill and refuse, then drain.
    for (int i = 0; i < 24; i++)
      put(8'(i));
    hold <= 1'b1;
    fork
      go();
    join_none
    repeat (60) @(posedge clk);
    #1;
    chk("rx ready full", 32'h0, {31'h0, rx_ready});
    @(posedge clk);
    hold <= 1'b0;
    wait fork;
    drain(0);
    head(8'h7f, `SXCP_MT_SET);
    put(8'h0a);
    put(8'h00);
    put(8'h05);
    put(8'h00);
    put(8'h07);
    put(8'h01);
    for (int k = 1; k <= 10; k++)
    begin
      put(8'h05);
      put(8'(k));
      put(k == 10 ? 8'h07 : 8'h06);
      put(8'h01);
    end
    put(`SXCP_EOX);
    go();
    drain(0);
    chk("id reset", 32'h0, {25'h0, dev_id});
    chk("preset reset", 32'ha, {28'h0, psel});
    chk("route reset", 32'h0, route);
    chk("stream none", 32'h0, {24'h0, s_out});
    // A broadcast request shows that the stores cleared preset 1's route for output 1.
    head(8'h7f, `SXCP_MT_REQ);
    put(`SXCP_EOX);
    go();
    drain(160);
    n = eq.size();
    chk("dump id reset", 32'h0, {24'h0, sxcp_sink_inst.q[n+5]});
    chk("dump sel reset", 32'ha, {24'h0, sxcp_sink_inst.q[n+8]});
    chk("dump preset clear", 32'h0, {24'h0, sxcp_sink_inst.q[n+16]});
    chk("dump end 2", 32'hf7, {24'h0, sxcp_sink_inst.q[n+159]});
    report_and_stop();
  end
endmodule
